// ---- rtl/flash_host_pkg.sv ----
`default_nettype none
package flash_host_pkg;
   // Geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int CMD_W  = 8;
   localparam int SECTOR_LSB = 11;
   localparam int BLOCK_LSB  = 15;
   // Command addresses and codes
   localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
   localparam logic [19:0] ADDR_UNLOCK2 = 20'h002AA;
   localparam logic [19:0] ADDR_QUERY1  = 20'h00055;
   localparam logic [19:0] ADDR_MAKER   = 20'h00000;
   localparam logic [19:0] ADDR_DEVCODE = 20'h00001;
   localparam logic [7:0]  CODE_UNLOCK1 = 8'hAA;
   localparam logic [7:0]  CODE_UNLOCK2 = 8'h55;
   localparam logic [7:0]  CODE_QUERY   = 8'h98;
   localparam logic [7:0]  CODE_QUERY1  = 8'h89;
   localparam logic [7:0]  CODE_SECID   = 8'h88;
   localparam logic [7:0]  CODE_IDENTRY = 8'h90;
   localparam logic [7:0]  CODE_EXIT    = 8'hF0;
   localparam logic [7:0]  CODE_PROGRAM = 8'hA0;
   localparam logic [7:0]  CODE_SECPROG = 8'hA5;
   localparam logic [7:0]  CODE_SECLOCK = 8'h85;
   localparam logic [7:0]  CODE_ERASE   = 8'h80;
   localparam logic [7:0]  CODE_SECTOR  = 8'h50;
   localparam logic [7:0]  CODE_BLOCK   = 8'h30;
   localparam logic [7:0]  CODE_CHIP    = 8'h10;
   localparam logic [7:0]  UPPER_FILL   = 8'h00;
   localparam int TOGGLE_BIT = 6;
   // Operations requested by the user
   typedef enum logic [3:0] {
      OP_READ     = 4'h0,
      OP_PROGRAM  = 4'h1,
      OP_SECTOR   = 4'h2,
      OP_BLOCK    = 4'h3,
      OP_CHIP     = 4'h4,
      OP_IDENTRY  = 4'h5,
      OP_QUERY3   = 4'h6,
      OP_QUERY1   = 4'h7,
      OP_SECENTRY = 4'h8,
      OP_EXIT     = 4'h9,
      OP_SECPROG  = 4'hA,
      OP_SECLOCK  = 4'hB
   } op_t;
   // Bus timing, ns
   localparam int CLK_NS        = 50;
   localparam int RC_NS         = 70;
   localparam int WP_NS         = 40;
   localparam int RC_CYC        = (RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC        = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESET_NS      = 500;
   localparam int RESET_CYC     = (RESET_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W         = 8;
endpackage
`default_nettype wire

// ---- rtl/flash_bus_cycle.sv ----
`default_nettype none
// One read or write cycle on the flash pins
module flash_bus_cycle #(
   parameter int HOLD = flash_host_pkg::RC_CYC
) (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                reset,
   // Request
   input  wire logic                                start,
   input  wire logic                                isWrite,
   input  wire logic [flash_host_pkg::ADDR_W-1:0]   addr,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   wdata,
   output logic                                     done,
   // Pins
   output logic                                     chipSel_n,
   output logic                                     outGate_n,
   output logic                                     writeStb_n,
   output logic [flash_host_pkg::ADDR_W-1:0]        addrOut,
   output logic [flash_host_pkg::DATA_W-1:0]        dataOut,
   output logic                                     dataOe_n
);
   if (HOLD < 1 || HOLD > 200) $error("HOLD out of range");
   logic [flash_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic busy_q, busy_d, done_d;
   logic cs_d, og_d, we_d, oe_d;
   logic [flash_host_pkg::ADDR_W-1:0] a_d;
   logic [flash_host_pkg::DATA_W-1:0] w_d;

   always_comb begin
      busy_d = busy_q;
      cnt_d  = cnt_q;
      done_d = 1'b0;
      cs_d = chipSel_n;
      og_d = outGate_n;
      we_d = writeStb_n;
      oe_d = dataOe_n;
      a_d  = addrOut;
      w_d  = dataOut;
      if (!busy_q && start) begin
         busy_d = 1'b1;
         cnt_d  = flash_host_pkg::CNT_W'(HOLD + 1);
         cs_d   = 1'b0;
         og_d   = isWrite;
         we_d   = !isWrite;
         oe_d   = !isWrite;
         a_d    = addr;
         w_d    = wdata;
      end else if (busy_q) begin
         cnt_d = cnt_q - 1'b1;
         if (cnt_q == 8'h01) begin
            we_d = 1'b1;
         end
         if (cnt_q == 8'h00) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            cs_d = 1'b1;
            og_d = 1'b1;
            oe_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busy_q <= 1'b0;
         cnt_q  <= '0;
         done   <= 1'b0;
         chipSel_n  <= 1'b1;
         outGate_n  <= 1'b1;
         writeStb_n <= 1'b1;
         dataOe_n   <= 1'b1;
         addrOut    <= '0;
         dataOut    <= '0;
      end else begin
         busy_q <= busy_d;
         cnt_q  <= cnt_d;
         done   <= done_d;
         chipSel_n  <= cs_d;
         outGate_n  <= og_d;
         writeStb_n <= we_d;
         dataOe_n   <= oe_d;
         addrOut    <= a_d;
         dataOut    <= w_d;
      end
   end
endmodule // flash_bus_cycle
`default_nettype wire

// ---- rtl/flash_query_id_mode_logic.sv ----
`default_nettype none
// How it works
// - Upper data byte driven low in commands
// - Query entry: unlock pair, 98H at 555H
// - Query entry: single 89H at 55H
// - Query mode holds until exit command
// - Exit sequence returns device to read
// - User segment only via security program
// - Completion polled on toggle bit and ready/busy pin
// - Security entry 88H at 555H, exit command
// - Chip select low gates every cycle
module flash_query_id_mode_logic #(
   parameter int RESET_CYCLES = flash_host_pkg::RESET_CYC
) (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                reset,
   // User command port
   input  wire logic                                reqValid,
   input  wire flash_host_pkg::op_t                 reqOp,
   input  wire logic [flash_host_pkg::ADDR_W-1:0]   reqAddr,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   reqData,
   output logic                                     reqReady,
   output logic                                     rspValid,
   output logic [flash_host_pkg::DATA_W-1:0]        rspData,
   // Flash pins
   output logic                                     chipSel_n,
   output logic                                     outGate_n,
   output logic                                     writeStb_n,
   output logic                                     hwReset_n,
   output logic                                     bootGuard_n,
   output logic [flash_host_pkg::ADDR_W-1:0]        addrOut,
   output logic [flash_host_pkg::DATA_W-1:0]        dataOut,
   output logic                                     dataOe_n,
   input  wire logic [flash_host_pkg::DATA_W-1:0]   dataIn,
   input  wire logic                                ready_busy_n,
   // Boot protect request
   input  wire logic                                protectBoot
);
   if (RESET_CYCLES < 1 || RESET_CYCLES > 255) $error("RESET_CYCLES out of range");

   typedef enum logic [5:0] {
      S_RESET = 6'b000001,
      S_IDLE  = 6'b000010,
      S_CMD   = 6'b000100,
      S_READ  = 6'b001000,
      S_POLL  = 6'b010000,
      S_WAIT  = 6'b100000
   } state_t;

   function automatic logic [flash_host_pkg::DATA_W-1:0] cmdWord(input logic [7:0] code);
      cmdWord = {flash_host_pkg::UPPER_FILL, code};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] rbSync_q;
   logic [2:0] tgSync_q;
   logic       rbBusy;
   always_ff @(posedge clk) begin
      if (reset) begin
         rbSync_q <= 3'h7;
         tgSync_q <= 3'h0;
      end else begin
         rbSync_q <= {rbSync_q[1:0], ready_busy_n};
         tgSync_q <= {tgSync_q[1:0], dataIn[flash_host_pkg::TOGGLE_BIT]};
      end
   end
   assign rbBusy = !rbSync_q[1] && !rbSync_q[2];

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   state_t state_q, state_d;
   logic [2:0] step_q, step_d, last_q, last_d;
   logic [7:0] rcnt_q, rcnt_d;
   flash_host_pkg::op_t op_q, op_d;
   logic [flash_host_pkg::ADDR_W-1:0] ra_q, ra_d;
   logic [flash_host_pkg::DATA_W-1:0] rd_q, rd_d;
   logic prevTg_q, prevTg_d;
   logic reqReady_d, rspValid_d, hwRst_d, guard_d;
   logic [flash_host_pkg::DATA_W-1:0] rspData_d;
   logic cycStart, cycWrite, cycDone;
   logic [flash_host_pkg::ADDR_W-1:0] cycAddr;
   logic [flash_host_pkg::DATA_W-1:0] cycData;

   // Command step table: address and data of write number step
   always_comb begin
      cycAddr = flash_host_pkg::ADDR_UNLOCK1;
      cycData = cmdWord(flash_host_pkg::CODE_UNLOCK1);
      if (step_q == 3'h1 || step_q == 3'h4) begin
         cycAddr = flash_host_pkg::ADDR_UNLOCK2;
         cycData = cmdWord(flash_host_pkg::CODE_UNLOCK2);
      end else if (step_q == 3'h3) begin
         cycData = cmdWord(flash_host_pkg::CODE_UNLOCK1);
      end else if (step_q == 3'h2) begin
         case (op_q)
            flash_host_pkg::OP_PROGRAM:  cycData = cmdWord(flash_host_pkg::CODE_PROGRAM);
            flash_host_pkg::OP_SECPROG:  cycData = cmdWord(flash_host_pkg::CODE_SECPROG);
            flash_host_pkg::OP_SECLOCK:  cycData = cmdWord(flash_host_pkg::CODE_SECLOCK);
            flash_host_pkg::OP_IDENTRY:  cycData = cmdWord(flash_host_pkg::CODE_IDENTRY);
            flash_host_pkg::OP_QUERY3:   cycData = cmdWord(flash_host_pkg::CODE_QUERY);
            flash_host_pkg::OP_SECENTRY: cycData = cmdWord(flash_host_pkg::CODE_SECID);
            flash_host_pkg::OP_EXIT:     cycData = cmdWord(flash_host_pkg::CODE_EXIT);
            default:                     cycData = cmdWord(flash_host_pkg::CODE_ERASE);
         endcase
      end
      if (op_q == flash_host_pkg::OP_QUERY1) begin
         cycAddr = flash_host_pkg::ADDR_QUERY1;
         cycData = cmdWord(flash_host_pkg::CODE_QUERY1);
      end else if (step_q == last_q && op_q != flash_host_pkg::OP_IDENTRY
                   && op_q != flash_host_pkg::OP_QUERY3 && op_q != flash_host_pkg::OP_SECENTRY
                   && op_q != flash_host_pkg::OP_EXIT) begin
         cycAddr = ra_q;
         case (op_q)
            flash_host_pkg::OP_SECTOR: begin
               cycAddr = {ra_q[19:flash_host_pkg::SECTOR_LSB], 11'h000};
               cycData = cmdWord(flash_host_pkg::CODE_SECTOR);
            end
            flash_host_pkg::OP_BLOCK: begin
               cycAddr = {ra_q[19:flash_host_pkg::BLOCK_LSB], 15'h0000};
               cycData = cmdWord(flash_host_pkg::CODE_BLOCK);
            end
            flash_host_pkg::OP_CHIP: begin
               cycAddr = flash_host_pkg::ADDR_UNLOCK1;
               cycData = cmdWord(flash_host_pkg::CODE_CHIP);
            end
            flash_host_pkg::OP_SECLOCK: cycData = cmdWord(8'h00);
            default: cycData = rd_q;
         endcase
      end
   end

   always_comb begin
      state_d = state_q;
      step_d = step_q;
      last_d = last_q;
      rcnt_d = rcnt_q;
      op_d = op_q;
      ra_d = ra_q;
      rd_d = rd_q;
      prevTg_d = prevTg_q;
      reqReady_d = 1'b0;
      rspValid_d = 1'b0;
      rspData_d = rspData;
      hwRst_d = 1'b1;
      guard_d = !protectBoot;
      cycStart = 1'b0;
      cycWrite = 1'b1;
      case (state_q)
         S_RESET: begin
            hwRst_d = 1'b0;
            rcnt_d = rcnt_q - 1'b1;
            if (rcnt_q == 8'h00) begin
               hwRst_d = 1'b1;
               state_d = S_IDLE;
               reqReady_d = 1'b1;
            end
         end
         S_IDLE: begin
            reqReady_d = 1'b1;
            if (reqValid) begin
               reqReady_d = 1'b0;
               op_d = reqOp;
               ra_d = reqAddr;
               rd_d = reqData;
               step_d = 3'h0;
               case (reqOp)
                  flash_host_pkg::OP_READ:   last_d = 3'h0;
                  flash_host_pkg::OP_QUERY1: last_d = 3'h0;
                  flash_host_pkg::OP_SECTOR,
                  flash_host_pkg::OP_BLOCK,
                  flash_host_pkg::OP_CHIP:   last_d = 3'h5;
                  default:                   last_d = 3'h3;
               endcase
               if (reqOp == flash_host_pkg::OP_IDENTRY || reqOp == flash_host_pkg::OP_QUERY3
                   || reqOp == flash_host_pkg::OP_SECENTRY || reqOp == flash_host_pkg::OP_EXIT) begin
                  last_d = 3'h2;
               end
               if (reqOp == flash_host_pkg::OP_READ) begin
                  state_d = S_READ;
               end else if (reqOp == flash_host_pkg::OP_EXIT && rbBusy) begin
                  state_d = S_WAIT;
               end else begin
                  state_d = S_CMD;
               end
            end
         end
         S_WAIT: begin
            if (!rbBusy) begin
               state_d = S_CMD;
            end
         end
         S_CMD: begin
            cycStart = 1'b1;
            if (cycDone) begin
               cycStart = 1'b0;
               step_d = step_q + 1'b1;
               if (step_q == last_q) begin
                  if (op_q == flash_host_pkg::OP_PROGRAM || op_q == flash_host_pkg::OP_SECPROG
                      || op_q == flash_host_pkg::OP_SECLOCK || last_q == 3'h5) begin
                     state_d = S_POLL;
                     ra_d = cycAddr;
                     prevTg_d = tgSync_q[2];
                  end else begin
                     state_d = S_IDLE;
                     rspValid_d = 1'b1;
                     reqReady_d = 1'b1;
                  end
               end
            end
         end
         S_READ: begin
            cycStart = 1'b1;
            cycWrite = 1'b0;
            if (cycDone) begin
               cycStart = 1'b0;
               rspData_d = dataIn;
               rspValid_d = 1'b1;
               reqReady_d = 1'b1;
               state_d = S_IDLE;
            end
         end
         S_POLL: begin
            cycStart = 1'b1;
            cycWrite = 1'b0;
            if (cycDone) begin
               cycStart = 1'b0;
               prevTg_d = tgSync_q[2];
               if (tgSync_q[2] == prevTg_q && !rbBusy) begin
                  rspData_d = dataIn;
                  rspValid_d = 1'b1;
                  reqReady_d = 1'b1;
                  state_d = S_IDLE;
               end
            end
         end
         default: state_d = S_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= S_RESET;
         step_q <= '0;
         last_q <= '0;
         rcnt_q <= 8'(RESET_CYCLES);
         op_q <= flash_host_pkg::OP_READ;
         ra_q <= '0;
         rd_q <= '0;
         prevTg_q <= 1'b0;
         reqReady <= 1'b0;
         rspValid <= 1'b0;
         rspData <= '0;
         hwReset_n <= 1'b0;
         bootGuard_n <= 1'b1;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         last_q <= last_d;
         rcnt_q <= rcnt_d;
         op_q <= op_d;
         ra_q <= ra_d;
         rd_q <= rd_d;
         prevTg_q <= prevTg_d;
         reqReady <= reqReady_d;
         rspValid <= rspValid_d;
         rspData <= rspData_d;
         hwReset_n <= hwRst_d;
         bootGuard_n <= guard_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin cycle engine
   flash_bus_cycle #(
      .HOLD (flash_host_pkg::RC_CYC)
   ) cycle (
      .clk        (clk),
      .reset      (reset),
      .start      (cycStart),
      .isWrite    (cycWrite),
      .addr       (state_q == S_CMD ? cycAddr : ra_q),
      .wdata      (cycData),
      .done       (cycDone),
      .chipSel_n  (chipSel_n),
      .outGate_n  (outGate_n),
      .writeStb_n (writeStb_n),
      .addrOut    (addrOut),
      .dataOut    (dataOut),
      .dataOe_n   (dataOe_n)
   );
endmodule // flash_query_id_mode_logic
`default_nettype wire

// ---- verif/flash_query_id_mode_logic_chk.sv ----
`default_nettype none
// Pin protocol checks on the host controller
module flash_query_id_mode_logic_chk #(
   parameter int RESET_CYCLES = 2
) (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Boot protect request
   input wire logic        protectBoot,
   // Flash pins
   input wire logic        chipSel_n,
   input wire logic        outGate_n,
   input wire logic        writeStb_n,
   input wire logic        hwReset_n,
   input wire logic        bootGuard_n,
   input wire logic [19:0] addrOut,
   input wire logic [15:0] dataOut,
   input wire logic        dataOe_n,
   input wire logic        ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   property p_rstHold; $fell(reset) |-> !hwReset_n [*2]; endproperty
   a_rstHold: assert property (p_rstHold) else $error("flash reset short");
   property p_noAcc; !hwReset_n |-> chipSel_n && writeStb_n; endproperty
   a_noAcc: assert property (p_noAcc) else $error("access in reset");
   property p_strb; !writeStb_n |-> !chipSel_n && outGate_n && !dataOe_n; endproperty
   a_strb: assert property (p_strb) else $error("bad write strobes");
   property p_rdLen; $fell(outGate_n) |-> (!outGate_n && !chipSel_n) [*3]; endproperty
   a_rdLen: assert property (p_rdLen) else $error("read too short");
   property p_noFight; !outGate_n |-> dataOe_n; endproperty
   a_noFight: assert property (p_noFight) else $error("bus contention");
   property p_upper;
      !dataOe_n && addrOut == 20'h002AA |-> dataOut[15:8] == flash_host_pkg::UPPER_FILL;
   endproperty
   a_upper: assert property (p_upper) else $error("upper byte level");
   property p_guard; $changed(protectBoot) |=> bootGuard_n == !$past(protectBoot); endproperty
   a_guard: assert property (p_guard) else $error("boot guard lag");
   property p_busyNoWr; !ready_busy_n [*4] |-> writeStb_n; endproperty
   a_busyNoWr: assert property (p_busyNoWr) else $error("write while busy");
   property p_addrHold; !outGate_n && $past(!outGate_n) |-> $stable(addrOut); endproperty
   a_addrHold: assert property (p_addrHold) else $error("read address moved");
   property p_unlock;
      $fell(writeStb_n) && addrOut == 20'h00555 && dataOut[7:0] == 8'hAA |->
         ##[1:20] ($fell(writeStb_n) && addrOut == 20'h002AA && dataOut[7:0] == 8'h55);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock pair broken");
   c_write: cover property ($rose(writeStb_n));
   c_busy: cover property ($fell(ready_busy_n));
   c_guard: cover property (!bootGuard_n && !writeStb_n);
endmodule // flash_query_id_mode_logic_chk
bind flash_query_id_mode_logic flash_query_id_mode_logic_chk #(.RESET_CYCLES(RESET_CYCLES)) uChk (
   .clk(clk), .reset(reset), .protectBoot(protectBoot), .chipSel_n(chipSel_n),
   .outGate_n(outGate_n), .writeStb_n(writeStb_n), .hwReset_n(hwReset_n),
   .bootGuard_n(bootGuard_n), .addrOut(addrOut), .dataOut(dataOut), .dataOe_n(dataOe_n),
   .ready_busy_n(ready_busy_n));
`default_nettype wire

// ---- verif/flash_dev_model.sv ----
`default_nettype none
// Behavioural flash device
module flash_dev_model #(
   parameter logic [15:0] MAKER_ID = 16'h0A5C, // Arbitrary value
   parameter logic [15:0] DEV_ID   = 16'h6B21, // Arbitrary value
   parameter int          BUSY     = 30
) (
   // Clock
   input  wire logic        clk,
   // Pins from host
   input  wire logic        chipSel_n,
   input  wire logic        outGate_n,
   input  wire logic        writeStb_n,
   input  wire logic        hwReset_n,
   input  wire logic        bootGuard_n,
   input  wire logic [19:0] addrOut,
   input  wire logic [15:0] dataOut,
   // Pins to host
   output logic      [15:0] devData,
   output logic             ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [int];
   logic [15:0] sec [0:135];
   logic [19:0] la;
   logic [15:0] lw;
   logic [7:0]  cmd;
   logic [1:0]  st, mode;
   logic        er, locked, tog, weQ, oeQ;
   int          busy;
   wire logic   unl = la[10:0] == 11'h555;
   initial begin
      {st, mode, er, locked, tog, busy, devData} = '0;
      weQ = 1'b1;
      oeQ = 1'b1;
      for (int i = 0; i < 136; i++) sec[i] = (i < 8) ? 16'hC3A0 + 16'(i) : 16'hFFFF;
   end
   assign ready_busy_n = (busy == 0);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wipe(input int lsb);
      foreach (mem[i])
         if ((i >> lsb) == (int'(la) >> lsb) && (bootGuard_n || i >= 'h2000))
            mem[i] = 16'hFFFF;
   endtask
   task automatic wr();
      if (busy > 0) return;
      if (lw[7:0] == 8'hF0) begin
         st <= 2'd0;
         mode <= 2'd0;
      end else case (st)
         2'd0: begin
            er <= er && unl && lw[7:0] == 8'hAA;
            if (unl && lw[7:0] == 8'hAA) st <= 2'd1;
            else if (la[10:0] == 11'h055 && lw[7:0] == 8'h89) mode <= 2'd2;
         end
         2'd1: st <= (la[10:0] == 11'h2AA && lw[7:0] == 8'h55) ? 2'd2 : 2'd0;
         2'd2: begin
            st <= 2'd0;
            er <= 1'b0;
            if (er) begin
               busy <= BUSY;
               case (lw[7:0])
                  8'h50: wipe(11);
                  8'h30: wipe(15);
                  8'h10: wipe(20);
                  default: busy <= 0;
               endcase
            end else if (unl) case (lw[7:0])
               8'h90: mode <= 2'd1;
               8'h98: mode <= 2'd2;
               8'h88: mode <= 2'd3;
               8'h80: er <= 1'b1;
               8'hA0, 8'hA5, 8'h85: begin
                  cmd <= lw[7:0];
                  st <= 2'd3;
               end
               default: ;
            endcase
         end
         default: begin
            st <= 2'd0;
            busy <= BUSY;
            if (cmd == 8'h85) locked <= 1'b1;
            else if (cmd == 8'hA5) begin
               if (!locked && la >= 20'h00008 && la < 20'h00088) sec[la] <= lw;
            end else if (bootGuard_n || la >= 20'h02000) mem[int'(la)] = lw;
         end
      endcase
   endtask
   always @(posedge clk) begin
      weQ <= writeStb_n;
      oeQ <= chipSel_n | outGate_n;
      if (busy > 0) busy <= busy - 1;
      if (!chipSel_n && !writeStb_n) begin
         la <= addrOut;
         lw <= dataOut;
      end
      if (!oeQ && (chipSel_n | outGate_n)) tog <= ~tog;
      if (chipSel_n || outGate_n) devData <= ~devData;
      else if (busy > 0) devData <= {9'h000, tog, 6'h00};
      else case (mode)
         2'd1: devData <= addrOut[0] ? DEV_ID : MAKER_ID;
         2'd2: devData <= 16'h5100 ^ addrOut[15:0];
         2'd3: devData <= (addrOut < 20'h00088) ? sec[addrOut] : 16'hFFFF;
         default: devData <= mem.exists(int'(addrOut)) ? mem[int'(addrOut)] : 16'hFFFF;
      endcase
      if (!hwReset_n) begin
         st <= 2'd0;
         mode <= 2'd0;
         busy <= 0;
      end else if (!weQ && writeStb_n) wr();
   end
endmodule // flash_dev_model
`default_nettype wire

// ---- verif/flash_query_id_mode_logic_tb.sv ----
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
// Bench for the flash host controller
module flash_query_id_mode_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] MAKER = 16'h0A5C; // Arbitrary value
   localparam logic [15:0] DEVID = 16'h6B21; // Arbitrary value
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic reqValid = 1'b0;
   flash_host_pkg::op_t reqOp = flash_host_pkg::OP_READ;
   logic [19:0] reqAddr = 20'h00000;
   logic [15:0] reqData = 16'h0000;
   logic protectBoot = 1'b0;
   logic reqReady, rspValid, chipSel_n, outGate_n, writeStb_n, hwReset_n, bootGuard_n;
   logic dataOe_n, ready_busy_n;
   logic [19:0] addrOut;
   logic [15:0] rspData, dataOut, dataIn, devData, rd;
   int miscompares = 0;
   int checked = 0;
   always #25 clk = ~clk;
   assign dataIn = !dataOe_n ? dataOut : devData;
   flash_query_id_mode_logic #(.RESET_CYCLES(2)) DUT (
      .clk(clk), .reset(reset), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
      .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .chipSel_n(chipSel_n), .outGate_n(outGate_n), .writeStb_n(writeStb_n),
      .hwReset_n(hwReset_n), .bootGuard_n(bootGuard_n), .addrOut(addrOut), .dataOut(dataOut),
      .dataOe_n(dataOe_n), .dataIn(dataIn), .ready_busy_n(ready_busy_n),
      .protectBoot(protectBoot));
   flash_dev_model #(.MAKER_ID(MAKER), .DEV_ID(DEVID)) flashDev (
      .clk(clk), .chipSel_n(chipSel_n), .outGate_n(outGate_n), .writeStb_n(writeStb_n),
      .hwReset_n(hwReset_n), .bootGuard_n(bootGuard_n), .addrOut(addrOut), .dataOut(dataOut),
      .devData(devData), .ready_busy_n(ready_busy_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic op(input flash_host_pkg::op_t o, input logic [19:0] a, input logic [15:0] d);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      reqValid <= 1'b1;
      reqOp <= o;
      reqAddr <= a;
      reqData <= d;
      @(posedge clk);
      reqValid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rspValid !== 1'b1 && n < 4000);
      rd = rspData;
      if (n >= 4000) begin
         miscompares++;
         $display("[FAIL] rspValid exp 1 got 0");
         conclude();
      end
   endtask
   task automatic rc(input string n, input logic [19:0] a, input logic [15:0] e);
      op(flash_host_pkg::OP_READ, a, 16'h0000);
      `CHK(n, e, rd)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_array();
      op(flash_host_pkg::OP_PROGRAM, 20'h04100, 16'h1234);
      rc("prog", 20'h04100, 16'h1234);
      rc("blank", 20'h04101, 16'hFFFF);
   endtask
   task automatic t_ident();
      op(flash_host_pkg::OP_IDENTRY, 20'h00555, 16'h0000);
      rc("maker", 20'h00000, MAKER);
      rc("devcode", 20'h00001, DEVID);
      op(flash_host_pkg::OP_EXIT, 20'h00555, 16'h0000);
      rc("idExit", 20'h04100, 16'h1234);
   endtask
   task automatic t_query();
      op(flash_host_pkg::OP_QUERY3, 20'h00555, 16'h0000);
      rc("q3", 20'h00010, 16'h5110);
      rc("q3hold", 20'h00011, 16'h5111);
      op(flash_host_pkg::OP_EXIT, 20'h00555, 16'h0000);
      rc("qExit", 20'h04100, 16'h1234);
      op(flash_host_pkg::OP_QUERY1, 20'h00055, 16'h0000);
      rc("q1", 20'h00020, 16'h5120);
      op(flash_host_pkg::OP_EXIT, 20'h00555, 16'h0000);
   endtask
   task automatic t_secure();
      op(flash_host_pkg::OP_SECENTRY, 20'h00555, 16'h0000);
      rc("secFactory", 20'h00003, 16'hC3A3);
      op(flash_host_pkg::OP_SECPROG, 20'h00008, 16'hBEEF);
      rc("secUser", 20'h00008, 16'hBEEF);
      op(flash_host_pkg::OP_PROGRAM, 20'h00009, 16'h1111);
      rc("secPlain", 20'h00009, 16'hFFFF);
      op(flash_host_pkg::OP_SECLOCK, 20'h00555, 16'h0000);
      op(flash_host_pkg::OP_SECPROG, 20'h0000A, 16'h2222);
      rc("secLocked", 20'h0000A, 16'hFFFF);
      op(flash_host_pkg::OP_EXIT, 20'h00555, 16'h0000);
      rc("plainArray", 20'h00009, 16'h1111);
      op(flash_host_pkg::OP_SECTOR, 20'h00000, 16'h0000);
      op(flash_host_pkg::OP_SECENTRY, 20'h00555, 16'h0000);
      rc("secNoErase", 20'h00008, 16'hBEEF);
      op(flash_host_pkg::OP_EXIT, 20'h00555, 16'h0000);
   endtask
   task automatic t_erase();
      op(flash_host_pkg::OP_PROGRAM, 20'h05000, 16'h5A5A);
      op(flash_host_pkg::OP_PROGRAM, 20'h05800, 16'hA5A5);
      op(flash_host_pkg::OP_PROGRAM, 20'h0C000, 16'h0F0F);
      op(flash_host_pkg::OP_SECTOR, 20'h05000, 16'h0000);
      rc("sectGone", 20'h05000, 16'hFFFF);
      rc("sectKept", 20'h05800, 16'hA5A5);
      op(flash_host_pkg::OP_BLOCK, 20'h08000, 16'h0000);
      rc("blkGone", 20'h0C000, 16'hFFFF);
      rc("blkKept", 20'h05800, 16'hA5A5);
      op(flash_host_pkg::OP_CHIP, 20'h00000, 16'h0000);
      rc("chipGone", 20'h05800, 16'hFFFF);
   endtask
   task automatic t_boot();
      protectBoot <= 1'b1;
      op(flash_host_pkg::OP_PROGRAM, 20'h00100, 16'h3C3C);
      rc("bootHeld", 20'h00100, 16'hFFFF);
      protectBoot <= 1'b0;
      op(flash_host_pkg::OP_PROGRAM, 20'h00100, 16'h3C3C);
      rc("bootOpen", 20'h00100, 16'h3C3C);
   endtask
   initial begin
      repeat (19) @(posedge clk);
      `CHK("hwReset_n", 1'b0, hwReset_n)
      @(posedge clk);
      reset <= 1'b0;
      t_array();
      t_ident();
      t_query();
      t_secure();
      t_erase();
      t_boot();
      conclude();
   end
endmodule // flash_query_id_mode_logic_tb
`default_nettype wire
